// File: rtl/sbh_regs.svh
// Constants for the satellite bus handover block
// Functional notes
// - Master open request enables address/data buffers
// - Unheld board runs as independent computer
// - Mailbox scratch region; program area from zero
// - Serial port at 40 hex, local only
// - Sixteen backplane address lines, A0 to A15
// - Separate 8-bit data-in and data-out groups
// - One bus owner at a time
// - Hold grant enables backplane driver/buffers
// - Local memory controls float while held
// - Refresh strobe stays local during transfers
// - Local CPU idles or runs otherwise
// - Backplane reset resets local CPU
// - Non-maskable interrupt starts initialization after reset
// - Interrupt from serial transmit/receive flags optionally
// - Jumper picks one select line
// - Isolated unless own select line active
// - Active select holds local CPU
`ifndef SBH_REGS_SVH
`define SBH_REGS_SVH
`define SBH_ADDR_W 16
`define SBH_DATA_W 8
`define SBH_SEL_N 8
`define SBH_SERIAL_PORT 8'h40
`define SBH_MAILBOX_BASE 16'hF800
`define SBH_PROG_BASE 16'h0000
`define SBH_TURN_NS 8
`define SBH_TURN_CYC ((`SBH_TURN_NS + 3) / 4)
`define SBH_NMI_NS 16
`define SBH_NMI_CYC ((`SBH_NMI_NS + 3) / 4)
`endif

// File: rtl/sbh_pkg.sv
// Types for the satellite bus handover block
package sbh_pkg;
	typedef enum logic [1:0] {
		SBH_LOCAL = 2'b00,
		SBH_REQ = 2'b01,
		SBH_HELD = 2'b10,
		SBH_DRAIN = 2'b11
	} sbh_own_e;
endpackage

// File: rtl/sbh_sync.sv
// Two flip-flop synchroniser for backplane inputs
module sbh_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
		end
	end
	assign q = s2_reg;
endmodule

// File: rtl/sbh_io_decode.sv
// Local I/O and memory region decode
`include "sbh_regs.svh"
module sbh_io_decode (
	input wire logic [`SBH_ADDR_W-1:0] addr,
	input wire logic iorq,
	input wire logic mreq,
	input wire logic held,
	output logic serial_sel,
	output logic mailbox_sel,
	output logic prog_sel
);
	// Port decode uses low byte only, as an 8-bit I/O space
	always_comb begin
		serial_sel = iorq && !held &&
			(addr[7:0] == `SBH_SERIAL_PORT);
		mailbox_sel = mreq && (addr >= `SBH_MAILBOX_BASE);
		// Offset compare keeps the test meaningful for a zero base
		prog_sel = mreq && ((addr - `SBH_PROG_BASE) <
			(`SBH_MAILBOX_BASE - `SBH_PROG_BASE));
	end
endmodule

// File: rtl/satellite_bus_handover.sv
// Bus ownership handover between local CPU and backplane master
`include "sbh_regs.svh"
module satellite_bus_handover #(
	parameter int AW = `SBH_ADDR_W,
	parameter int DW = `SBH_DATA_W,
	parameter int NSEL = `SBH_SEL_N
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [NSEL-1:0] satellite_select_line,
	input wire logic [NSEL-1:0] satellite_id_jumper,
	input wire logic bp_reset,
	input wire logic [AW-1:0] bp_addr,
	input wire logic [DW-1:0] bp_data_out,
	input wire logic bp_mreq,
	input wire logic bp_rd,
	input wire logic bp_wr,
	input wire logic bp_phantom,
	output logic [DW-1:0] bp_data_in,
	output logic bp_data_in_oe,
	input wire logic [AW-1:0] cpu_addr,
	input wire logic [DW-1:0] cpu_dout,
	input wire logic cpu_mreq,
	input wire logic cpu_iorq,
	input wire logic cpu_rd,
	input wire logic cpu_wr,
	input wire logic bus_hold_grant_n,
	input wire logic serial_tx_space_flag,
	input wire logic serial_rx_avail_flag,
	input wire logic irq_tx_en,
	input wire logic irq_rx_en,
	output logic bus_hold_request_n,
	output logic cpu_reset,
	output logic cpu_nmi,
	output logic cpu_int,
	input wire logic dram_refresh_strobe_n,
	output logic dram_refresh_out_n,
	input wire logic [DW-1:0] mem_rdata,
	output logic [AW-1:0] mem_addr,
	output logic [DW-1:0] mem_wdata,
	output logic mem_mreq,
	output logic mem_rd,
	output logic mem_wr,
	output logic mem_ctl_oe,
	output logic dma_buf_en,
	output logic serial_sel,
	output logic mailbox_sel,
	output logic prog_sel,
	output logic master_owns
);
	localparam int TURN = `SBH_TURN_CYC;
	localparam int NMIC = `SBH_NMI_CYC;

	logic [NSEL-1:0] sel_s;
	logic rst_s;
	logic grant_s;
	logic [AW-1:0] baddr_s;
	logic [DW-1:0] bdo_s;
	logic [3:0] bctl_s;
	logic [NSEL-1:0] jmp_s;

	// All backplane inputs and the CPU hold grant cross from outside the clock
	sbh_sync #(.W(NSEL)) u_sel (
		.clk(clk), .rst(rst), .d(satellite_select_line), .q(sel_s));
	// The strap is a pin too, so it is settled before the decode sees it
	sbh_sync #(.W(NSEL)) u_jmp (
		.clk(clk), .rst(rst), .d(satellite_id_jumper), .q(jmp_s));
	sbh_sync #(.W(2)) u_lvl (
		.clk(clk), .rst(rst), .d({bp_reset, ~bus_hold_grant_n}),
		.q({rst_s, grant_s}));
	sbh_sync #(.W(AW + DW + 4)) u_bus (
		.clk(clk), .rst(rst),
		.d({bp_addr, bp_data_out, bp_mreq, bp_rd, bp_wr, bp_phantom}),
		.q({baddr_s, bdo_s, bctl_s}));

	function automatic logic one_hot(input logic [NSEL-1:0] v);
		return (v != '0) && ((v & (v - 1'b1)) == '0);
	endfunction

	logic [NSEL-1:0] jumper_reg;
	logic [NSEL-1:0] jumper_next;
	logic selected;
	sbh_pkg::sbh_own_e own_reg;
	sbh_pkg::sbh_own_e own_next;
	logic [3:0] turn_reg;
	logic [3:0] turn_next;
	logic rst_d_reg;
	logic rst_d_next;
	logic [3:0] nmi_reg;
	logic [3:0] nmi_next;

	// Jumper is a strap: caught by a clock edge, only while backplane reset is held
	always_comb begin
		jumper_next = jumper_reg;
		if (rst_s)
			jumper_next = one_hot(jmp_s) ?
				jmp_s : '0;
	end
	// Only a legal single pair can ever match a select line
	assign selected = |(sel_s & jumper_reg);

	always_comb begin
		own_next = own_reg;
		turn_next = turn_reg;
		unique case (own_reg)
			sbh_pkg::SBH_LOCAL: begin
				if (selected)
					own_next = sbh_pkg::SBH_REQ;
			end
			sbh_pkg::SBH_REQ: begin
				if (!selected)
					own_next = sbh_pkg::SBH_LOCAL;
				else if (grant_s)
					own_next = sbh_pkg::SBH_HELD;
			end
			sbh_pkg::SBH_HELD: begin
				if (!selected) begin
					own_next = sbh_pkg::SBH_DRAIN;
					turn_next = 4'(TURN);
				end
			end
			sbh_pkg::SBH_DRAIN: begin
				if (turn_reg > 4'h1)
					turn_next = turn_reg - 4'h1;
				else
					own_next = sbh_pkg::SBH_LOCAL;
			end
		endcase
		if (rst_s)
			own_next = sbh_pkg::SBH_LOCAL;
	end

	// Hold and release the local CPU strictly through the handshake
	assign bus_hold_request_n = !(own_reg == sbh_pkg::SBH_REQ ||
		own_reg == sbh_pkg::SBH_HELD);
	// Buffers only while the grant is in and the master still selects us
	assign dma_buf_en = (own_reg == sbh_pkg::SBH_HELD) && grant_s;
	assign master_owns = dma_buf_en;
	// Local memory controls float from request until drain ends
	assign mem_ctl_oe = (own_reg == sbh_pkg::SBH_LOCAL);

	// At most one source drives the internal bus, none in turnover
	always_comb begin
		mem_addr = '0;
		mem_wdata = '0;
		mem_mreq = 1'b0;
		mem_rd = 1'b0;
		mem_wr = 1'b0;
		if (dma_buf_en) begin
			mem_addr = baddr_s;
			mem_wdata = bdo_s;
			// Cycles without PHANTOM belong to the master's own memory
			mem_mreq = bctl_s[3] && bctl_s[0];
			mem_rd = bctl_s[2] && bctl_s[0];
			mem_wr = bctl_s[1] && bctl_s[0];
		end else if (mem_ctl_oe) begin
			mem_addr = cpu_addr;
			mem_wdata = cpu_dout;
			mem_mreq = cpu_mreq;
			mem_rd = cpu_rd;
			mem_wr = cpu_wr;
		end
	end

	// Refresh is always local, even under master control
	assign dram_refresh_out_n = dram_refresh_strobe_n;

	logic [DW-1:0] din_reg;
	logic [DW-1:0] din_next;
	logic din_oe_reg;
	logic din_oe_next;
	// Answer only a master read taken while PHANTOM marks satellite side
	always_comb begin
		din_oe_next = dma_buf_en && bctl_s[3] && bctl_s[2] &&
			bctl_s[0];
		din_next = din_oe_next ? mem_rdata : din_reg;
	end
	assign bp_data_in = din_reg;
	assign bp_data_in_oe = din_oe_reg;

	sbh_io_decode u_dec (
		.addr(mem_addr),
		.iorq(cpu_iorq),
		.mreq(mem_mreq),
		.held(!mem_ctl_oe),
		.serial_sel(serial_sel),
		.mailbox_sel(mailbox_sel),
		.prog_sel(prog_sel)
	);

	// Backplane reset also resets the CPU; NMI pulse follows the release
	always_comb begin
		rst_d_next = rst_s;
		nmi_next = nmi_reg;
		if (rst_d_reg && !rst_s)
			nmi_next = 4'(NMIC);
		else if (nmi_reg != 4'h0)
			nmi_next = nmi_reg - 4'h1;
	end
	assign cpu_reset = rst_s || rst;
	assign cpu_nmi = (nmi_reg != 4'h0);
	assign cpu_int = (irq_tx_en && serial_tx_space_flag) ||
		(irq_rx_en && serial_rx_avail_flag);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			jumper_reg <= '0;
			own_reg <= sbh_pkg::SBH_LOCAL;
			turn_reg <= 4'h0;
			rst_d_reg <= 1'b0;
			nmi_reg <= 4'h0;
			din_reg <= '0;
			din_oe_reg <= 1'b0;
		end else begin
			jumper_reg <= jumper_next;
			own_reg <= own_next;
			turn_reg <= turn_next;
			rst_d_reg <= rst_d_next;
			nmi_reg <= nmi_next;
			din_reg <= din_next;
			din_oe_reg <= din_oe_next;
		end
	end
endmodule

// File: bench/sbh_checker.sv
// Port assertions for the satellite bus handover block
module sbh_checker #(
	parameter int NSEL = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [NSEL-1:0] satellite_select_line,
	input wire logic bp_reset,
	input wire logic [15:0] cpu_addr,
	input wire logic cpu_iorq,
	input wire logic bus_hold_grant_n,
	input wire logic bus_hold_request_n,
	input wire logic cpu_reset,
	input wire logic cpu_nmi,
	input wire logic dram_refresh_strobe_n,
	input wire logic dram_refresh_out_n,
	input wire logic mem_ctl_oe,
	input wire logic dma_buf_en,
	input wire logic serial_sel
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_refresh_local: assert property (
		dram_refresh_out_n == dram_refresh_strobe_n)
		else $error("refresh strobe not passed through");
	a_one_owner: assert property (!(mem_ctl_oe && dma_buf_en))
		else $error("both bus owners enabled");
	a_serial_local: assert property (serial_sel |->
		mem_ctl_oe && cpu_iorq && cpu_addr[7:0] == 8'h40)
		else $error("serial port selected wrongly");
	a_grant_opens: assert property ($rose(dma_buf_en) |->
		!$past(bus_hold_grant_n, 2) && !bus_hold_request_n)
		else $error("early buffers");
	a_buffers_first: assert property ($rose(mem_ctl_oe) |->
		!$past(dma_buf_en, 2))
		else $error("local controls back before buffers off");
	a_select_holds: assert property (!bus_hold_request_n |->
		|$past(satellite_select_line, 3)) else $error("hold without select");
	a_nmi_pulse: assert property ($rose(cpu_nmi) |-> cpu_nmi[*4] ##1 !cpu_nmi)
		else $error("init interrupt pulse length");
	a_reset_cpu: assert property (bp_reset[*3] |-> cpu_reset)
		else $error("backplane reset not passed to cpu");
endmodule

// File: bench/sbh_master_model.sv
// Backplane master model: select lines and memory cycles
module sbh_master_model (
	output logic [7:0] satellite_select_line,
	output logic bp_reset,
	output logic [15:0] bp_addr,
	output logic [7:0] bp_data_out,
	output logic bp_mreq,
	output logic bp_rd,
	output logic bp_wr,
	output logic bp_phantom,
	input wire logic clk
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		satellite_select_line = 8'h00;
		bp_reset = 1'h1;
		bp_addr = 16'h5A5A;
		bp_data_out = 8'hA5;
		{bp_mreq, bp_rd, bp_wr, bp_phantom} = 4'h0;
	end
	task automatic pick(input logic [7:0] s);
		@(negedge clk);
		satellite_select_line = s;
	endtask
	task automatic sysrst(input logic v);
		@(negedge clk);
		bp_reset = v;
	endtask
	// Phantom marks every cycle aimed at satellite memory
	task automatic cyc(input logic [15:0] a, input logic [7:0] d,
		input logic r);
		@(negedge clk);
		bp_addr = a;
		bp_data_out = d;
		{bp_mreq, bp_rd, bp_wr, bp_phantom} = {1'h1, r, ~r, 1'h1};
	endtask
	// Released lines flip so a stale value never looks valid
	task automatic idle();
		@(negedge clk);
		bp_addr = ~bp_addr;
		bp_data_out = ~bp_data_out;
		{bp_mreq, bp_rd, bp_wr, bp_phantom} = 4'h0;
	endtask
endmodule

// File: bench/test_satellite_bus_handover.sv
// Self-checking bench for the satellite bus handover block
`include "sbh_regs.svh"
module test_satellite_bus_handover;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int NSEL = 8;
	logic clk = 1'h0, rst = 1'h1, cpu_mreq = 1'h0, cpu_iorq = 1'h0;
	logic cpu_rd = 1'h0, cpu_wr = 1'h0, bus_hold_grant_n = 1'h1;
	logic dram_refresh_strobe_n = 1'h1, irq_tx_en = 1'h0, irq_rx_en = 1'h0;
	logic serial_tx_space_flag = 1'h0, serial_rx_avail_flag = 1'h0;
	logic [7:0] satellite_id_jumper = 8'h04, cpu_dout = 8'h00;
	logic [7:0] mem_rdata = 8'h00, satellite_select_line, bp_data_out;
	logic [7:0] bp_data_in, mem_wdata, d;
	logic [15:0] cpu_addr = 16'h0000, bp_addr, mem_addr;
	logic bp_reset, bp_mreq, bp_rd, bp_wr, bp_phantom, bp_data_in_oe;
	logic bus_hold_request_n, cpu_reset, cpu_nmi, cpu_int, dram_refresh_out_n;
	logic mem_mreq, mem_rd, mem_wr, mem_ctl_oe, dma_buf_en, serial_sel;
	logic mailbox_sel, prog_sel, master_owns;
	int fail_count = 0, cmp_count = 0;
	time t0;
	always #2 clk = ~clk;
	satellite_bus_handover #(.NSEL(NSEL)) uut (.*);
	sbh_master_model mst (.*);
	function automatic logic f_int(logic [3:0] x);
		return (x[0] & x[2]) | (x[1] & x[3]);
	endfunction
	function automatic logic f_ser(logic [15:0] a, logic io);
		return io && a[7:0] == `SBH_SERIAL_PORT;
	endfunction
	task automatic chk(input logic [15:0] got, exp, input string m);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask
	task automatic tally_and_finish();
		$display("compares %0d, mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Bounded wait: 0 hold, 1 buffers, 2 read, 3 local, 4 nmi
	task automatic wt(input int s, input logic v);
		for (int i = 0; i < 40; i++) begin
			@(negedge clk);
			if ((s == 0 ? bus_hold_request_n : s == 1 ? dma_buf_en :
				s == 2 ? bp_data_in_oe : s == 3 ? mem_ctl_oe : cpu_nmi) === v)
				return;
		end
		fail_count++;
		$display("wrong value at %0t: wait ran out", $time);
		tally_and_finish();
	endtask
	initial begin
		void'($urandom(37));
		repeat (8) @(negedge clk);
		rst = 1'h0;
		repeat (4) @(negedge clk);
		chk(cpu_reset, 1'h1, "cpu reset");
		mst.sysrst(1'h0);
		wt(4, 1'h1);
		t0 = $time;
		wt(4, 1'h0);
		chk(16'(($time - t0) / 4), 16'h0004, "nmi");
		$display("reset test done");
		for (int i = 0; i < 16; i++) begin
			@(negedge clk);
			{irq_rx_en, irq_tx_en, serial_rx_avail_flag,
				serial_tx_space_flag} = 4'(i);
			cpu_addr = i[0] ? 16'h0040 :
				(i[3] ? 16'hF7FF : 16'($urandom)) + 16'(i[2]);
			cpu_iorq = i[1];
			cpu_mreq = ~i[1];
			cpu_rd = i[3];
			cpu_wr = ~i[3];
			cpu_dout = 8'($urandom);
			dram_refresh_strobe_n = i[2];
			#1;
			chk(cpu_int, f_int(4'(i)), "int");
			chk(serial_sel, f_ser(cpu_addr, cpu_iorq), "serial");
			chk(mem_addr, cpu_addr, "local addr");
			chk(mailbox_sel, cpu_mreq &&
				cpu_addr >= `SBH_MAILBOX_BASE, "mbox");
			chk(prog_sel, cpu_mreq &&
				cpu_addr < `SBH_MAILBOX_BASE, "prog");
			chk({master_owns, mem_mreq, mem_rd, mem_wr, mem_wdata},
				{1'h0, cpu_mreq, cpu_rd, cpu_wr, cpu_dout}, "local ctl");
			chk(dram_refresh_out_n, 16'(i[2]), "refresh");
		end
		$display("local test done");
		mst.pick(8'h01);
		repeat (6) @(negedge clk);
		chk(bus_hold_request_n, 1'h1, "foreign select");
		mst.pick(8'h04);
		wt(0, 1'h0);
		chk(mem_ctl_oe, 1'h0, "local controls");
		repeat ($urandom_range(3)) @(negedge clk);
		bus_hold_grant_n = 1'h0;
		wt(1, 1'h1);
		cpu_iorq = 1'h1;
		cpu_addr = 16'h0040;
		#1;
		chk(serial_sel, 1'h0, "serial held");
		d = 8'($urandom);
		mem_rdata = d;
		mst.cyc(16'($urandom), 8'h00, 1'h1);
		wt(2, 1'h1);
		chk(bp_data_in, d, "read data");
		chk({master_owns, mem_mreq, mem_rd, mem_wr}, 4'hE, "master ctl");
		mst.cyc(16'hF801, ~d, 1'h0);
		repeat (4) @(negedge clk);
		chk(mem_addr, 16'hF801, "master addr");
		chk({mem_wr, mem_wdata}, {1'h1, ~d}, "write");
		mst.idle();
		mst.pick(8'h00);
		wt(1, 1'h0);
		chk(mem_ctl_oe, 1'h0, "turnover");
		bus_hold_grant_n = 1'h1;
		wt(3, 1'h1);
		$display("transfer test done");
		tally_and_finish();
	end
endmodule
bind satellite_bus_handover sbh_checker #(.NSEL(NSEL)) chk (.*);
